// ==== cke_consts.svh ====
// Constants shared by both ends of the output-enable configuration link.
// Assumes a 200 MHz system clock and a pulled-up two-wire link.
`ifndef CKE_CONSTS_SVH
`define CKE_CONSTS_SVH
`define CKE_SLAVE_ADDR 7'h69
`define CKE_DIR_WRITE 1'b0
`define CKE_CMD_CODE 8'h00
`define CKE_HDR_BYTES 6'd3
`define CKE_CFG_BYTES 6'd3
`define CKE_ACK_BIT 4'd8
`define CKE_NUM_OUTS 10
`define CKE_CFG0_RST 8'h0f
`define CKE_CFG1_RST 8'hf0
`define CKE_CFG2_RST 8'hc0
`define CKE_CFG0_EN_MASK 8'h0f
`define CKE_CFG1_EN_MASK 8'hf0
`define CKE_CFG2_EN_MASK 8'hc0
`define CKE_HCLK_NS 5
`define CKE_SCL_PERIOD_NS 10000
`define CKE_QUARTER_CYC (`CKE_SCL_PERIOD_NS / (4 * `CKE_HCLK_NS))
`define CKE_HOLD_LIMIT_MS 10
`define CKE_HOLD_LIMIT_CYC (`CKE_HOLD_LIMIT_MS * 1000000 / `CKE_HCLK_NS)
`define CKE_REG_CTRL 32'h0000_0000
`define CKE_REG_DATA 32'h0000_0004
`define CKE_REG_STAT 32'h0000_0008
`define CKE_CTRL_START 8
`define CKE_STAT_BUSY 0
`define CKE_STAT_DONE 1
`define CKE_STAT_NACK 2
`endif

// ==== cke_pkg.sv ====
// Types shared by both ends of the output-enable configuration link.
// Assumes cke_consts.svh supplies all numeric constants.
package cke_pkg;
	typedef enum logic [1:0] {
		CKE_DEV_IDLE,
		CKE_DEV_RECV,
		CKE_DEV_SKIP
	} cke_dev_state_t;
	typedef enum logic [1:0] {
		CKE_HST_IDLE,
		CKE_HST_START,
		CKE_HST_BIT,
		CKE_HST_STOP
	} cke_hst_state_t;
endpackage

// ==== cke_link_if.sv ====
// Two-wire link between the configuration host and the clock buffer.
// Assumes external pull-ups: a line is low only while some end drives it.
`timescale 1ns/1ps
interface cke_link_if;
	logic host_scl_oe_n;
	logic host_sda_oe_n;
	logic dev_sda_oe_n;
	logic serial_clock_line;
	logic serial_data_line;
	// Open-drain resolution; a released line reads high.
	assign serial_clock_line = host_scl_oe_n;
	assign serial_data_line = host_sda_oe_n & dev_sda_oe_n;
	modport host (
		output host_scl_oe_n,
		output host_sda_oe_n,
		input serial_clock_line,
		input serial_data_line
	);
	modport device (
		output dev_sda_oe_n,
		input serial_clock_line,
		input serial_data_line
	);
endinterface

// ==== cke_device.sv ====
// Clock buffer end: serial receiver for three enable bytes and output gating.
// Assumes link lines arrive asynchronously and are sampled by hclk.
`timescale 1ns/1ps
`include "cke_consts.svh"
module cke_device #(
	parameter int unsigned HOLD_LIMIT_CYC = `CKE_HOLD_LIMIT_CYC
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Serial link.
	cke_link_if.device link,
	// Clock fan-out path.
	input wire logic buf_clk_in,
	input wire logic output_enable,
	input wire logic low_power_state,
	output logic [`CKE_NUM_OUTS-1:0] clk_out,
	output logic clk_out_oe_n,
	// Status.
	output logic [23:0] cfg_readback,
	output logic transfer_valid
);

	////////////////////////////////////////////////////////////////////////
	// Synchronisers and edge detection.
	logic scl_s1_q;
	logic scl_s2_q;
	logic scl_p_q;
	logic sda_s1_q;
	logic sda_s2_q;
	logic sda_p_q;
	logic pd_s1_q;
	logic pd_s2_q;
	logic oe_s1_q;
	logic oe_s2_q;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_s1_q <= link.serial_clock_line;
			scl_s2_q <= scl_s1_q;
			scl_p_q <= scl_s2_q;
			sda_s1_q <= link.serial_data_line;
			sda_s2_q <= sda_s1_q;
			sda_p_q <= sda_s2_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pd_s1_q <= 1'b0;
			pd_s2_q <= 1'b0;
			oe_s1_q <= 1'b0;
			oe_s2_q <= 1'b0;
		end
		else
		begin
			pd_s1_q <= low_power_state;
			pd_s2_q <= pd_s1_q;
			oe_s1_q <= output_enable;
			oe_s2_q <= oe_s1_q;
		end
	end

	assign scl_rise = scl_s2_q & ~scl_p_q;
	assign scl_fall = ~scl_s2_q & scl_p_q;
	assign start_seen = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
	assign stop_seen = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;

	////////////////////////////////////////////////////////////////////////
	// Receive state machine.
	cke_pkg::cke_dev_state_t state_q;
	logic [7:0] shift_q;
	logic [3:0] bit_cnt_q;
	logic ack_phase_q;
	logic ack_drive_q;
	logic [5:0] byte_no_q;
	logic valid_q;
	logic hold_expired;
	logic byte_end;
	logic addr_match;
	logic cfg_wr;
	logic [5:0] cfg_idx;

	assign byte_end = scl_fall & (bit_cnt_q == `CKE_ACK_BIT) & ~ack_phase_q;
	// The direction bit is not decoded; only writes are ever sent.
	assign addr_match = (shift_q[7:1] == `CKE_SLAVE_ADDR);
	assign cfg_idx = byte_no_q - `CKE_HDR_BYTES;
	assign cfg_wr = (state_q == cke_pkg::CKE_DEV_RECV) & byte_end & valid_q
		& ~pd_s2_q & (byte_no_q >= `CKE_HDR_BYTES)
		& (cfg_idx < `CKE_CFG_BYTES);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q <= cke_pkg::CKE_DEV_IDLE;
			shift_q <= 8'h00;
			bit_cnt_q <= 4'h0;
			ack_phase_q <= 1'b0;
			ack_drive_q <= 1'b0;
			byte_no_q <= 6'h00;
			valid_q <= 1'b0;
		end
		else if (pd_s2_q || stop_seen)
		begin
			state_q <= cke_pkg::CKE_DEV_IDLE;
			ack_phase_q <= 1'b0;
			ack_drive_q <= 1'b0;
		end
		else if (start_seen)
		begin
			state_q <= cke_pkg::CKE_DEV_RECV;
			bit_cnt_q <= 4'h0;
			ack_phase_q <= 1'b0;
			ack_drive_q <= 1'b0;
			byte_no_q <= 6'h00;
			valid_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				cke_pkg::CKE_DEV_RECV, cke_pkg::CKE_DEV_SKIP:
				begin
					if (scl_rise && bit_cnt_q != `CKE_ACK_BIT)
					begin
						shift_q <= {shift_q[6:0], sda_s2_q};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					if (byte_end)
					begin
						ack_phase_q <= 1'b1;
						if (byte_no_q != 6'h3f)
						begin
							byte_no_q <= byte_no_q + 6'h01;
						end
						// General call and foreign addresses stay unanswered.
						if (state_q == cke_pkg::CKE_DEV_RECV &&
							(byte_no_q != 6'h00 || addr_match))
						begin
							ack_drive_q <= 1'b1;
						end
						else
						begin
							state_q <= cke_pkg::CKE_DEV_SKIP;
						end
					end
					else if (scl_fall && ack_phase_q)
					begin
						ack_phase_q <= 1'b0;
						ack_drive_q <= 1'b0;
						bit_cnt_q <= 4'h0;
						if (byte_no_q == `CKE_HDR_BYTES &&
							state_q == cke_pkg::CKE_DEV_RECV)
						begin
							valid_q <= 1'b1;
						end
					end
				end
				default:
				begin
					ack_drive_q <= 1'b0;
				end
			endcase
			if (hold_expired)
			begin
				ack_drive_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Guard against holding the data line low too long.
	logic [31:0] hold_cnt_q;

	assign hold_expired = (hold_cnt_q >= HOLD_LIMIT_CYC - 1);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hold_cnt_q <= 32'h0000_0000;
		end
		else if (!ack_drive_q)
		begin
			hold_cnt_q <= 32'h0000_0000;
		end
		else if (!hold_expired)
		begin
			hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
		end
	end

	assign link.dev_sda_oe_n = ~ack_drive_q;

	////////////////////////////////////////////////////////////////////////
	// Configuration bytes.
	logic [7:0] cfg_q [0:2];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cfg_q[0] <= `CKE_CFG0_RST;
			cfg_q[1] <= `CKE_CFG1_RST;
			cfg_q[2] <= `CKE_CFG2_RST;
		end
		else if (cfg_wr)
		begin
			cfg_q[cfg_idx[1:0]] <= shift_q;
		end
	end

	assign cfg_readback = {cfg_q[2], cfg_q[1], cfg_q[0]};
	assign transfer_valid = valid_q;

	////////////////////////////////////////////////////////////////////////
	// Output gating.
	logic [`CKE_NUM_OUTS-1:0] out_en;
	logic [7:0] en0;
	logic [7:0] en1;
	logic [7:0] en2;

	// Unused and reserved bits are masked off.
	assign en0 = cfg_q[0] & `CKE_CFG0_EN_MASK;
	assign en1 = cfg_q[1] & `CKE_CFG1_EN_MASK;
	assign en2 = cfg_q[2] & `CKE_CFG2_EN_MASK;
	assign out_en = {en2[7:6], en1[7:4], en0[3:0]};

	genvar g;
	generate
		for (g = 0; g < `CKE_NUM_OUTS; g = g + 1)
		begin : gen_out
			assign clk_out[g] = buf_clk_in & out_en[g];
		end
	endgenerate

	assign clk_out_oe_n = ~oe_s2_q;

endmodule

// ==== cke_host.sv ====
// Host end: AHB-Lite registers and a block-write master for the link.
// Assumes a single AHB-Lite master and a pulled-up two-wire link.
`timescale 1ns/1ps
`include "cke_consts.svh"
module cke_host #(
	parameter int unsigned QUARTER_CYC = `CKE_QUARTER_CYC
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Serial link.
	cke_link_if.host link
);

	////////////////////////////////////////////////////////////////////////
	// Bus slave.
	logic dp_wr_q;
	logic dp_rd_q;
	logic [31:0] dp_addr_q;
	logic [23:0] data_q;
	logic [1:0] count_q;
	logic done_q;
	logic nack_q;
	logic busy;
	logic start_req;
	logic set_done;
	logic set_nack;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_wr_q <= 1'b0;
			dp_rd_q <= 1'b0;
			dp_addr_q <= 32'h0000_0000;
		end
		else if (hready)
		begin
			dp_wr_q <= hsel & htrans[1] & hwrite;
			dp_rd_q <= hsel & htrans[1] & ~hwrite;
			dp_addr_q <= haddr;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign start_req = dp_wr_q & (dp_addr_q == `CKE_REG_CTRL) & ~busy
		& hwdata[`CKE_CTRL_START] & (hwdata[1:0] != 2'b00);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			data_q <= 24'h00_0000;
			count_q <= 2'b00;
		end
		else if (dp_wr_q && !busy)
		begin
			if (dp_addr_q == `CKE_REG_CTRL)
			begin
				count_q <= hwdata[1:0];
			end
			else if (dp_addr_q == `CKE_REG_DATA)
			begin
				data_q <= hwdata[23:0];
			end
		end
	end

	// Status flags clear on writing one; a new event wins over the clear.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			done_q <= 1'b0;
			nack_q <= 1'b0;
		end
		else
		begin
			if (set_done)
			begin
				done_q <= 1'b1;
			end
			else if (dp_wr_q && dp_addr_q == `CKE_REG_STAT &&
				hwdata[`CKE_STAT_DONE])
			begin
				done_q <= 1'b0;
			end
			if (set_nack)
			begin
				nack_q <= 1'b1;
			end
			else if (dp_wr_q && dp_addr_q == `CKE_REG_STAT &&
				hwdata[`CKE_STAT_NACK])
			begin
				nack_q <= 1'b0;
			end
		end
	end

	always_comb
	begin
		hrdata = 32'h0000_0000;
		if (!dp_rd_q)
		begin
			hrdata = 32'h0000_0000;
		end
		else if (dp_addr_q == `CKE_REG_CTRL)
		begin
			hrdata = {30'h0000_0000, count_q};
		end
		else if (dp_addr_q == `CKE_REG_DATA)
		begin
			hrdata = {8'h00, data_q};
		end
		else if (dp_addr_q == `CKE_REG_STAT)
		begin
			hrdata = {29'h0000_0000, nack_q, done_q, busy};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link master.
	cke_pkg::cke_hst_state_t state_q;
	logic [31:0] qcnt_q;
	logic [1:0] phase_q;
	logic [3:0] bit_q;
	logic [2:0] byte_q;
	logic scl_oe_n_q;
	logic sda_oe_n_q;
	logic sda_s1_q;
	logic sda_s2_q;
	logic tick;
	logic [7:0] tx_byte;
	logic [2:0] last_byte;
	logic [23:0] tx_data;

	assign busy = (state_q != cke_pkg::CKE_HST_IDLE);
	assign tick = (qcnt_q == QUARTER_CYC - 1);
	assign last_byte = 3'd2 + {1'b0, count_q};
	// Initialize-to-zero and reserved bits always go out as zero.
	assign tx_data = data_q & {`CKE_CFG2_EN_MASK, `CKE_CFG1_EN_MASK,
		`CKE_CFG0_EN_MASK};
	assign set_nack = (state_q == cke_pkg::CKE_HST_BIT) & tick
		& (phase_q == 2'd2) & (bit_q == `CKE_ACK_BIT) & sda_s2_q;
	assign set_done = (state_q == cke_pkg::CKE_HST_STOP) & tick
		& (phase_q == 2'd2);

	// Address with write, command, count, then data byte 0 upward.
	always_comb
	begin
		tx_byte = 8'h00;
		case (byte_q)
			3'd0: tx_byte = {`CKE_SLAVE_ADDR, `CKE_DIR_WRITE};
			3'd1: tx_byte = `CKE_CMD_CODE;
			3'd2: tx_byte = {6'h00, count_q};
			3'd3: tx_byte = tx_data[7:0];
			3'd4: tx_byte = tx_data[15:8];
			3'd5: tx_byte = tx_data[23:16];
			default: tx_byte = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
		end
		else
		begin
			sda_s1_q <= link.serial_data_line;
			sda_s2_q <= sda_s1_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			qcnt_q <= 32'h0000_0000;
		end
		else if (!busy || tick)
		begin
			qcnt_q <= 32'h0000_0000;
		end
		else
		begin
			qcnt_q <= qcnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q <= cke_pkg::CKE_HST_IDLE;
			phase_q <= 2'd0;
			bit_q <= 4'h0;
			byte_q <= 3'd0;
			scl_oe_n_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
		end
		else
		begin
			case (state_q)
				cke_pkg::CKE_HST_IDLE:
				begin
					if (start_req)
					begin
						state_q <= cke_pkg::CKE_HST_START;
						phase_q <= 2'd0;
						bit_q <= 4'h0;
						byte_q <= 3'd0;
					end
				end
				cke_pkg::CKE_HST_START:
				begin
					if (tick)
					begin
						phase_q <= phase_q + 2'd1;
						if (phase_q == 2'd0)
						begin
							sda_oe_n_q <= 1'b0;
						end
						else
						begin
							scl_oe_n_q <= 1'b0;
							phase_q <= 2'd0;
							state_q <= cke_pkg::CKE_HST_BIT;
						end
					end
				end
				cke_pkg::CKE_HST_BIT:
				begin
					if (tick)
					begin
						phase_q <= phase_q + 2'd1;
						if (phase_q == 2'd0)
						begin
							sda_oe_n_q <= (bit_q == `CKE_ACK_BIT) ? 1'b1 :
								tx_byte[3'd7 - bit_q[2:0]];
						end
						else if (phase_q == 2'd1)
						begin
							scl_oe_n_q <= 1'b1;
						end
						else if (phase_q == 2'd2 && set_nack)
						begin
							state_q <= cke_pkg::CKE_HST_STOP;
							phase_q <= 2'd0;
						end
						else if (phase_q == 2'd3)
						begin
							scl_oe_n_q <= 1'b0;
							bit_q <= bit_q + 4'h1;
							if (bit_q == `CKE_ACK_BIT)
							begin
								bit_q <= 4'h0;
								byte_q <= byte_q + 3'd1;
								if (byte_q == last_byte)
								begin
									state_q <= cke_pkg::CKE_HST_STOP;
								end
							end
						end
					end
				end
				default:
				begin
					if (tick)
					begin
						phase_q <= phase_q + 2'd1;
						if (phase_q == 2'd0)
						begin
							scl_oe_n_q <= 1'b0;
							sda_oe_n_q <= 1'b0;
						end
						else if (phase_q == 2'd1)
						begin
							scl_oe_n_q <= 1'b1;
						end
						else
						begin
							sda_oe_n_q <= 1'b1;
							phase_q <= 2'd0;
							state_q <= cke_pkg::CKE_HST_IDLE;
						end
					end
				end
			endcase
		end
	end

	assign link.host_scl_oe_n = scl_oe_n_q;
	assign link.host_sda_oe_n = sda_oe_n_q;

endmodule

// ==== cke_monitor.sv ====
// Concurrent checks on the two-wire link between host and device ends.
// Assumes hclk samples the resolved lines and sits beside the link.
`timescale 1ns/1ps
module cke_monitor #(
	parameter int unsigned HOLD_LIMIT_CYC = 2000000
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Link signals.
	input wire logic host_scl_oe_n,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_oe_n,
	input wire logic serial_clock_line,
	input wire logic serial_data_line
);
	localparam int ACK_MIN = 28;
	localparam int ACK_MAX = 36;
	logic scl_q;
	logic sda_q;
	logic [7:0] sh_q;
	logic [3:0] bit_q;
	logic [1:0] byte_q;
	logic [31:0] low_q;
	logic rise;
	logic strt;
	logic ack_rise;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	assign rise = serial_clock_line & ~scl_q;
	assign strt = sda_q & ~serial_data_line & serial_clock_line;
	assign ack_rise = rise & (bit_q == 4'd8);
	////////////////////////////////////////////////////////////////////////
	// Byte decoder: shifts bits at clock rises and counts bytes in a frame.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sh_q <= 8'h00;
			bit_q <= 4'h0;
			byte_q <= 2'h0;
		end
		else
		begin
			scl_q <= serial_clock_line;
			sda_q <= serial_data_line;
			if (strt)
			begin
				bit_q <= 4'h0;
				byte_q <= 2'h0;
			end
			else if (rise)
			begin
				if (bit_q < 4'd8)
					sh_q <= {sh_q[6:0], serial_data_line};
				bit_q <= (bit_q == 4'd8) ? 4'h0 : bit_q + 4'h1;
				if (bit_q == 4'd8 && byte_q != 2'd3)
					byte_q <= byte_q + 2'h1;
			end
		end
	end
	// Counts cycles for which the device holds the data line low.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			low_q <= 32'h0;
		else
			low_q <= dev_sda_oe_n ? 32'h0 : low_q + 32'h1;
	end
	////////////////////////////////////////////////////////////////////////
	sequence ack_release;
		##[ACK_MIN:ACK_MAX] $rose(dev_sda_oe_n);
	endsequence
	AST_ADDR_BYTE: assert property (ack_rise && byte_q == 2'd0 |-> sh_q == 8'hd2)
		else $error("address byte wrong");
	AST_CMD_BYTE: assert property (ack_rise && byte_q == 2'd1 |-> sh_q == 8'h00)
		else $error("command byte not zero");
	AST_COUNT_BYTE: assert property (ack_rise && byte_q == 2'd2 |-> sh_q inside {[8'h01:8'h03]})
		else $error("byte count out of range");
	AST_ACK_LOW: assert property (ack_rise |-> !serial_data_line && !dev_sda_oe_n)
		else $error("byte not acknowledged");
	AST_ACK_SPAN: assert property ($fell(dev_sda_oe_n) |-> ack_release)
		else $error("acknowledge span wrong");
	AST_DEV_CHANGE_LOW: assert property ($changed(dev_sda_oe_n) |-> !serial_clock_line)
		else $error("device changed data while clock high");
	AST_NO_TRANSMIT: assert property ($fell(dev_sda_oe_n) |-> bit_q == 4'd8)
		else $error("device drove data outside acknowledge slot");
	AST_HOLD_LIMIT: assert property (low_q < HOLD_LIMIT_CYC)
		else $error("data line held low too long");
	AST_CLK_HIGH: assert property ($rose(host_scl_oe_n) |-> serial_clock_line [*8])
		else $error("clock high phase too short");
endmodule

// ==== tb_top.sv ====
// Self-checking bench: AHB-Lite writes through the host, link to the device.
// Assumes both ends meet in cke_link_if with the link at reduced counts.
`timescale 1ns/1ps
`include "cke_consts.svh"
module tb_top;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic buf_clk_in;
	logic output_enable;
	logic low_power_state;
	logic [`CKE_NUM_OUTS-1:0] clk_out;
	logic clk_out_oe_n;
	logic [23:0] cfg_readback;
	logic transfer_valid;
	int err_count;
	int comparisons;
	int i;
	int n;
	logic [31:0] rd;
	logic [23:0] row_data [5];
	logic [1:0] row_cnt [5];
	logic [23:0] row_cfg [5];
	cke_link_if i_cke_link_if ();
	cke_host #(.QUARTER_CYC(8)) i_cke_host (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.link(i_cke_link_if.host));
	cke_device #(.HOLD_LIMIT_CYC(200)) i_cke_device (.hclk(hclk),
		.hresetn(hresetn), .link(i_cke_link_if.device),
		.buf_clk_in(buf_clk_in), .output_enable(output_enable),
		.low_power_state(low_power_state), .clk_out(clk_out),
		.clk_out_oe_n(clk_out_oe_n), .cfg_readback(cfg_readback),
		.transfer_valid(transfer_valid));
	cke_monitor #(.HOLD_LIMIT_CYC(200)) i_cke_monitor (.hclk(hclk),
		.hresetn(hresetn), .host_scl_oe_n(i_cke_link_if.host_scl_oe_n),
		.host_sda_oe_n(i_cke_link_if.host_sda_oe_n),
		.dev_sda_oe_n(i_cke_link_if.dev_sda_oe_n),
		.serial_clock_line(i_cke_link_if.serial_clock_line),
		.serial_data_line(i_cke_link_if.serial_data_line));
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		$display("Comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One single AHB-Lite transfer: address phase, then data phase.
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Polls the status register until the frame reports done or 3000 polls have been made.
	task wait_done;
		n = 0;
		do
		begin
			ahb(1'b0, `CKE_REG_STAT, 32'h0);
			n++;
		end
		while (rd[1] !== 1'b1 && n < 3000);
	endtask
	function automatic logic [9:0] exp_out(input logic [23:0] c);
		return {c[23:22], c[15:12], c[3:0]};
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	initial
	begin
		#300000;
		err_count++;
		end_of_test();
	end
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		buf_clk_in = 1'b0;
		output_enable = 1'b0;
		low_power_state = 1'b0;
		err_count = 0;
		comparisons = 0;
		row_data = '{24'h000000, 24'h40a005, 24'h0000ff, 24'hc05003, 24'h80f009};
		row_cnt = '{2'd3, 2'd3, 2'd1, 2'd2, 2'd3};
		row_cfg = '{24'h000000, 24'h40a005, 24'h40a00f, 24'h405003, 24'h80f009};
		repeat (20) @(posedge hclk);
		chk(cfg_readback, 24'hc0f00f);
		chk(clk_out_oe_n, 1'b1);
		hresetn <= 1'b1;
		output_enable <= 1'b1;
		buf_clk_in <= 1'b1;
		repeat (4) @(posedge hclk);
		#1 chk(clk_out_oe_n, 1'b0);
		chk(clk_out, 10'h3ff);
		ahb(1'b0, 32'h0000_0010, 32'h0);
		chk(rd, 32'h0);
		chk(hresp, 1'b0);
		for (i = 0; i < 5; i++)
		begin
			ahb(1'b1, `CKE_REG_DATA, {8'h00, row_data[i]});
			ahb(1'b1, `CKE_REG_CTRL, 32'h100 | {30'h0, row_cnt[i]});
			wait_done();
			chk(rd[2:0], 3'b010);
			#1 chk(cfg_readback, row_cfg[i]);
			chk(transfer_valid, 1'b1);
			chk(clk_out, exp_out(row_cfg[i]));
			@(posedge hclk);
			buf_clk_in <= 1'b0;
			#1 chk(clk_out, 10'h000);
			@(posedge hclk);
			buf_clk_in <= 1'b1;
			ahb(1'b1, `CKE_REG_STAT, 32'h2);
			ahb(1'b0, `CKE_REG_STAT, 32'h0);
			chk(rd[1], 1'b0);
		end
		// A data write while the link is busy must be refused.
		ahb(1'b1, `CKE_REG_CTRL, 32'h101);
		ahb(1'b1, `CKE_REG_DATA, 32'h0000_0001);
		wait_done();
		chk(rd[2:0], 3'b010);
		ahb(1'b0, `CKE_REG_DATA, 32'h0);
		chk(rd, {8'h00, row_data[4]});
		ahb(1'b0, `CKE_REG_CTRL, 32'h0);
		chk(rd, 32'h1);
		chk(cfg_readback, row_cfg[4]);
		output_enable <= 1'b0;
		repeat (3) @(posedge hclk);
		output_enable <= 1'b1;
		low_power_state <= 1'b1;
		#1 chk(clk_out_oe_n, 1'b1);
		repeat (4) @(posedge hclk);
		#1 chk(i_cke_link_if.dev_sda_oe_n, 1'b1);
		chk(cfg_readback, row_cfg[4]);
		@(posedge hclk);
		low_power_state <= 1'b0;
		hresetn <= 1'b0;
		@(posedge hclk);
		#1 chk(cfg_readback, 24'hc0f00f);
		chk(transfer_valid, 1'b0);
		@(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		end_of_test();
	end
endmodule
